// File: rtl/isw_pkg.sv
// package: shared constants and types of the interrupt and sleep/wake-up controller
package isw_pkg;
   // ==========================================================================
   // register map (byte addresses, one 32-bit word each)
   localparam logic [7:0] ADDR_IRQ_EN = 8'h00;
   localparam logic [7:0] ADDR_IRQ_REQ = 8'h04;
   localparam logic [7:0] ADDR_EDGE_SEL = 8'h08;
   localparam logic [7:0] ADDR_STACK_PTR = 8'h0C;
   localparam logic [7:0] ADDR_MISC = 8'h10;
   localparam logic [7:0] ADDR_COMP_CTRL = 8'h14;
   localparam logic [7:0] ADDR_COMP_SEL = 8'h18;
   localparam logic [7:0] ADDR_PIN_WAKE = 8'h1C;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   // ==========================================================================
   // sizes, field positions and reset values
   localparam int NUM_SRC = 7;
   localparam int NUM_PINS = 8;
   localparam int MISC_FAST_WAKE_BIT = 5;
   localparam int COMP_EN_BIT = 7;
   localparam int COMP_WAKE_BIT = 6;
   localparam int PIN_INPUT_LSB = 8;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [6:0] RST_IRQ = 7'h00;
   localparam logic [13:0] RST_EDGE = 14'h0000;
   localparam logic [15:0] RST_PINS = 16'h0000;
   // ==========================================================================
   // vector, stack step and edge codes
   localparam logic [15:0] VECTOR_ADDR = 16'h0010;
   localparam logic [7:0] SP_STEP = 8'h02;
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   // ==========================================================================
   // wake-up times in slow rc clock periods
   localparam logic [11:0] WAKE_NORMAL_TICKS = 12'hBB8;
   localparam logic [11:0] WAKE_FAST_TICKS = 12'h02D;
   // ==========================================================================
   // core instruction codes presented with each instruction boundary
   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_ENGINT = 3'h1,
      CMD_DISGINT = 3'h2,
      CMD_RETI = 3'h3,
      CMD_PUSHAF = 3'h4,
      CMD_POPAF = 3'h5,
      CMD_LIGHT_SLEEP = 3'h6,
      CMD_DEEP_SLEEP = 3'h7
   } isw_cmd_e;
   // power state, one-hot
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_LIGHT = 4'h2,
      ST_DEEP = 4'h4,
      ST_WAKE = 4'h8
   } isw_state_e;
endpackage : isw_pkg

// File: rtl/isw_edge.sv
// module: per-source edge detector with selectable rising, falling or both edges
`timescale 1ns/100ps
module isw_edge #(
   parameter int N = 7
) (
   input wire logic core_clk, // system clock
   input wire logic rst_n, // asynchronous reset, active low
   input wire logic [N-1:0] level, // source levels
   input wire logic [2*N-1:0] sel, // two select bits per source
   output logic [N-1:0] hit // one-cycle event per source
);
   logic [N-1:0] prev;

   // ==========================================================================
   // previous level, reset low so a high source at reset counts as a rise
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev <= '0;
      end else begin
         prev <= level;
      end
   end

   // edge choice per source; codes 2 and 3 both mean either edge
   for (genvar i = 0; i < N; i++) begin : g_src
      always_comb begin
         case (sel[2*i +: 2])
            isw_pkg::EDGE_RISE: hit[i] = level[i] & ~prev[i]; // [R3]
            isw_pkg::EDGE_FALL: hit[i] = ~level[i] & prev[i]; // [R3]
            default: hit[i] = level[i] ^ prev[i]; // [R3]
         endcase
      end
   end

   edge_real_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
      |hit |-> (level != prev))
      else $error("edge event without a level change");
endmodule : isw_edge

// File: rtl/isw_ctrl.sv
// module: interrupt controller and light/deep sleep wake-up control with apb registers
// Function
// [R1] seven request sources, each with enable
// [R2] hardware sets flags; software write clears
// [R3] edge select: rising, falling or both
// [R4] global enable gates all enabled sources
// [R5] software keeps stack pointer bit 0 clear
// [R6] push/pop accumulator and flags via stack
// [R7] take: stack pc, sp+2, disable, vector
// [R8] flags set even when source disabled
// [R9] return: pop pc, sp-2, re-enable, resume
// [R10] request flags readable by software
// [R11] software reserves two stack bytes per level
// [R12] light sleep gates system clock only
// [R13] timers stop on system or dead clock
// [R14] timer match wakes light sleep
// [R15] comparator wakes when both enables set
// [R16] pin toggle wakes if input enabled
// [R17] slow rc stays on except in deep sleep; restart from it
// [R18] deep sleep: oscillators off, pins wake
// [R19] timer wake ignored in deep sleep
// [R20] program memory off; resume after sleep
// [R21] normal wake takes 3000 slow clocks
// [R22] fast wake takes 45; misc bit 5
// [R23] fast boot forces fast wake
// [R24] take only at boundary with global enable
// [R25] one vector; flags stay for software
`timescale 1ns/100ps
module isw_ctrl #(
   parameter int NSRC = isw_pkg::NUM_SRC,
   parameter int NPIN = isw_pkg::NUM_PINS
) (
   input wire logic core_clk, // system clock, 125 MHz
   input wire logic rst_n, // asynchronous reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction, high for write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic pready, // apb ready
   output logic [31:0] prdata, // apb read data
   output logic pslverr, // apb error on unmapped address
   input wire logic [NSRC-1:0] src_level, // request source levels
   input wire logic core_step, // instruction boundary pulse
   input wire logic [2:0] core_cmd, // instruction finishing at the boundary
   input wire logic [15:0] core_pc, // address of the next instruction
   input wire logic [7:0] accumulator, // current accumulator
   input wire logic [7:0] status_flags, // current status flags
   input wire logic [15:0] stk_rdata, // stack read data, one cycle after read
   output logic [7:0] stk_addr, // stack address
   output logic [15:0] stk_wdata, // stack write data
   output logic stk_we, // stack write pulse
   output logic stk_re, // stack read pulse
   output logic pc_load, // load pc_value into the program counter
   output logic [15:0] pc_value, // new program counter
   output logic irq_taken, // pulse with the vector load
   output logic af_load, // load accumulator and flags
   output logic [7:0] acc_out, // restored accumulator
   output logic [7:0] flag_out, // restored status flags
   input wire logic [NPIN-1:0] pin_level, // wake pin levels
   input wire logic [2:0] timer_match, // timers reached set value
   input wire logic [2:0] timer_on_sys, // timer clocked from system clock
   input wire logic [2:0] timer_osc_off, // timer oscillator disabled
   input wire logic comparator_event, // comparator output event
   input wire logic slow_tick, // one pulse per slow rc period
   input wire logic fast_rc_cfg, // fast rc enabled by software
   input wire logic crystal_cfg, // crystal enabled by software
   input wire logic fast_boot, // fast boot-up option strap
   output logic sys_clk_en, // system clock gate enable
   output logic fast_rc_osc_en, // fast rc oscillator enable
   output logic crystal_osc_en, // crystal oscillator enable
   output logic slow_rc_osc_en, // slow rc oscillator enable
   output logic program_memory_on, // program memory power
   output logic core_halt, // core stops executing
   output logic clk_from_slow, // system clock restarts from slow rc
   output logic [2:0] timer_run // timer count enables
);
   // ==========================================================================
   // declarations
   logic [NSRC-1:0] irq_en, irq_flags, src_hit;
   logic [2*NSRC-1:0] edge_sel;
   logic [7:0] stack_pointer, misc, comparator_control, comparator_select;
   logic [NPIN-1:0] pin_dier, pin_input, pin_prev;
   logic gie, pop_pc, pop_af, fast_boot_q, boot_seen, wake_fast;
   logic [11:0] wake_cnt;
   logic acc_ph, done, wr_do;
   logic [31:0] rdata_c;
   logic map_hit;
   logic take, pending, pin_toggle;
   logic wake_light, wake_deep;
   isw_pkg::isw_state_e state, next_state;
   isw_pkg::isw_cmd_e cmd;

   // decode used by the write path and the checks
   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : is_reg

   assign cmd = isw_pkg::isw_cmd_e'(core_cmd);

   // ==========================================================================
   // apb slave: one wait state, write commits at the edge that sees pready
   assign acc_ph = psel & penable & ~pready;
   assign done = psel & penable & pready;
   assign wr_do = done & pwrite;

   always_comb begin
      rdata_c = 32'h0000_0000;
      map_hit = 1'b1;
      case (paddr)
         isw_pkg::ADDR_IRQ_EN: rdata_c[NSRC-1:0] = irq_en;
         isw_pkg::ADDR_IRQ_REQ: rdata_c[NSRC-1:0] = irq_flags; // [R10]
         isw_pkg::ADDR_EDGE_SEL: rdata_c[2*NSRC-1:0] = edge_sel;
         isw_pkg::ADDR_STACK_PTR: rdata_c[7:0] = stack_pointer;
         isw_pkg::ADDR_MISC: rdata_c[7:0] = misc;
         isw_pkg::ADDR_COMP_CTRL: rdata_c[7:0] = comparator_control;
         isw_pkg::ADDR_COMP_SEL: rdata_c[7:0] = comparator_select;
         isw_pkg::ADDR_PIN_WAKE: rdata_c[2*NPIN-1:0] = {pin_input, pin_dier};
         isw_pkg::ADDR_STATUS: rdata_c[6:0] = {state, gie, clk_from_slow, fast_boot_q};
         default: map_hit = 1'b0;
      endcase
   end

   // answer registers; read data is captured in the cycle before pready rises
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= acc_ph;
         prdata <= (acc_ph & ~pwrite) ? rdata_c : 32'h0000_0000;
         pslverr <= acc_ph & ~map_hit;
      end
   end

   // software configuration; unmapped writes are dropped
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en <= isw_pkg::RST_IRQ;
         edge_sel <= isw_pkg::RST_EDGE;
         misc <= isw_pkg::RST_BYTE;
         comparator_control <= isw_pkg::RST_BYTE;
         comparator_select <= isw_pkg::RST_BYTE;
         {pin_input, pin_dier} <= isw_pkg::RST_PINS;
      end else if (wr_do) begin
         if (is_reg(paddr, isw_pkg::ADDR_IRQ_EN)) irq_en <= pwdata[NSRC-1:0]; // [R1]
         if (is_reg(paddr, isw_pkg::ADDR_EDGE_SEL)) edge_sel <= pwdata[2*NSRC-1:0]; // [R3]
         if (is_reg(paddr, isw_pkg::ADDR_MISC)) misc <= pwdata[7:0];
         if (is_reg(paddr, isw_pkg::ADDR_COMP_CTRL)) comparator_control <= pwdata[7:0];
         if (is_reg(paddr, isw_pkg::ADDR_COMP_SEL)) comparator_select <= pwdata[7:0];
         if (is_reg(paddr, isw_pkg::ADDR_PIN_WAKE)) begin
            {pin_input, pin_dier} <= pwdata[2*NPIN-1:0];
         end
      end
   end

   // ==========================================================================
   // request flags
   isw_edge #(.N(NSRC)) u_edge (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .level(src_level),
      .sel(edge_sel),
      .hit(src_hit)
   );

   // a write clears the bits written as zero; a same-cycle event wins the clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_flags <= isw_pkg::RST_IRQ;
      end else if (wr_do && is_reg(paddr, isw_pkg::ADDR_IRQ_REQ)) begin
         irq_flags <= (irq_flags & pwdata[NSRC-1:0]) | src_hit; // [R2]
      end else begin
         irq_flags <= irq_flags | src_hit; // [R2] [R8]
      end
   end

   // ==========================================================================
   // interrupt entry, return and accumulator save/restore
   assign pending = |(irq_flags & irq_en); // [R1] [R25]
   // an instruction that itself acts on the stack or enable is finished first
   assign take = core_step & (cmd == isw_pkg::CMD_NONE) & gie & pending
      & (state == isw_pkg::ST_RUN); // [R4] [R24]

   // global enable
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gie <= 1'b0;
      end else if (take) begin
         gie <= 1'b0; // [R7]
      end else if (core_step) begin
         case (cmd)
            isw_pkg::CMD_ENGINT: gie <= 1'b1; // [R4]
            isw_pkg::CMD_DISGINT: gie <= 1'b0; // [R4]
            isw_pkg::CMD_RETI: gie <= 1'b1; // [R9]
            default: gie <= gie;
         endcase
      end
   end

   // stack traffic; pops wait one cycle for the stack read data
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stack_pointer <= isw_pkg::RST_BYTE;
         stk_addr <= isw_pkg::RST_BYTE;
         stk_wdata <= 16'h0000;
         stk_we <= 1'b0;
         stk_re <= 1'b0;
         pc_load <= 1'b0;
         pc_value <= 16'h0000;
         irq_taken <= 1'b0;
         af_load <= 1'b0;
         acc_out <= isw_pkg::RST_BYTE;
         flag_out <= isw_pkg::RST_BYTE;
         pop_pc <= 1'b0;
         pop_af <= 1'b0;
      end else begin
         stk_we <= 1'b0;
         stk_re <= 1'b0;
         pc_load <= 1'b0;
         irq_taken <= 1'b0;
         af_load <= 1'b0;
         pop_pc <= 1'b0;
         pop_af <= 1'b0;
         if (take) begin
            stk_addr <= stack_pointer; // [R7]
            stk_wdata <= core_pc;
            stk_we <= 1'b1;
            stack_pointer <= stack_pointer + isw_pkg::SP_STEP; // [R7]
            pc_value <= isw_pkg::VECTOR_ADDR; // [R7]
            pc_load <= 1'b1;
            irq_taken <= 1'b1;
         end else if (core_step && cmd == isw_pkg::CMD_PUSHAF) begin
            stk_addr <= stack_pointer; // [R6]
            stk_wdata <= {status_flags, accumulator};
            stk_we <= 1'b1;
            stack_pointer <= stack_pointer + isw_pkg::SP_STEP;
         end else if (core_step && (cmd == isw_pkg::CMD_RETI || cmd == isw_pkg::CMD_POPAF)) begin
            stk_addr <= stack_pointer - isw_pkg::SP_STEP; // [R9] [R6]
            stk_re <= 1'b1;
            stack_pointer <= stack_pointer - isw_pkg::SP_STEP;
            pop_pc <= (cmd == isw_pkg::CMD_RETI);
            pop_af <= (cmd == isw_pkg::CMD_POPAF);
         end else if (wr_do && is_reg(paddr, isw_pkg::ADDR_STACK_PTR)) begin
            stack_pointer <= pwdata[7:0]; // bit 0 is left as software wrote it [R5]
         end
         if (pop_pc) begin
            pc_value <= stk_rdata; // resume at the interrupted instruction [R9]
            pc_load <= 1'b1;
         end
         if (pop_af) begin
            {flag_out, acc_out} <= stk_rdata; // [R6]
            af_load <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // wake sources
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_prev <= '0;
      end else begin
         pin_prev <= pin_level;
      end
   end

   assign pin_toggle = |((pin_level ^ pin_prev) & pin_dier); // [R16]
   // light sleep also asks for digital input direction on the toggling pin
   assign wake_light = |((pin_level ^ pin_prev) & pin_dier & pin_input) // [R16]
      | |(timer_match & ~timer_on_sys & ~timer_osc_off) // [R14]
      | (comparator_event & comparator_control[isw_pkg::COMP_EN_BIT]
         & comparator_select[isw_pkg::COMP_WAKE_BIT]); // [R15]
   assign wake_deep = pin_toggle; // timers never reach here [R18] [R19]

   // fast boot strap caught once after reset release
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fast_boot_q <= 1'b0;
         boot_seen <= 1'b0;
      end else if (!boot_seen) begin
         fast_boot_q <= fast_boot;
         boot_seen <= 1'b1;
      end
   end

   // ==========================================================================
   // power state machine
   always_comb begin
      next_state = state;
      case (state)
         isw_pkg::ST_RUN: begin
            if (core_step && cmd == isw_pkg::CMD_LIGHT_SLEEP) next_state = isw_pkg::ST_LIGHT;
            if (core_step && cmd == isw_pkg::CMD_DEEP_SLEEP) next_state = isw_pkg::ST_DEEP;
         end
         isw_pkg::ST_LIGHT: if (wake_light) next_state = isw_pkg::ST_WAKE;
         isw_pkg::ST_DEEP: if (wake_deep) next_state = isw_pkg::ST_WAKE; // [R18]
         isw_pkg::ST_WAKE: begin
            if (slow_tick && wake_cnt + 12'h001 >= (wake_fast ? isw_pkg::WAKE_FAST_TICKS
                  : isw_pkg::WAKE_NORMAL_TICKS)) next_state = isw_pkg::ST_RUN; // [R21] [R22]
         end
         default: next_state = isw_pkg::ST_RUN;
      endcase
   end

   // state, wake timer and restart clock choice
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= isw_pkg::ST_RUN;
         wake_cnt <= 12'h000;
         wake_fast <= 1'b0;
         clk_from_slow <= 1'b0;
      end else begin
         // software switches the clock back by any write to the misc register;
         // the clear comes first so a wake entry in the same cycle keeps the flag set
         if (wr_do && is_reg(paddr, isw_pkg::ADDR_MISC)) clk_from_slow <= 1'b0;
         state <= next_state;
         if (state != isw_pkg::ST_WAKE && next_state == isw_pkg::ST_WAKE) begin
            wake_cnt <= 12'h000;
            wake_fast <= fast_boot_q | misc[isw_pkg::MISC_FAST_WAKE_BIT]; // [R23] [R22]
            clk_from_slow <= 1'b1; // [R17]
         end else if (state == isw_pkg::ST_WAKE && slow_tick) begin
            wake_cnt <= wake_cnt + 12'h001; // [R21]
         end
      end
   end

   // clock, oscillator and power outputs follow the next state, so they are registered
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_clk_en <= 1'b1;
         fast_rc_osc_en <= 1'b0;
         crystal_osc_en <= 1'b0;
         slow_rc_osc_en <= 1'b1;
         program_memory_on <= 1'b1;
         core_halt <= 1'b0;
         timer_run <= 3'h0;
      end else begin
         sys_clk_en <= (next_state == isw_pkg::ST_RUN); // [R12]
         fast_rc_osc_en <= fast_rc_cfg & (next_state != isw_pkg::ST_DEEP); // [R12] [R18]
         crystal_osc_en <= crystal_cfg & (next_state != isw_pkg::ST_DEEP); // [R18]
         slow_rc_osc_en <= (next_state != isw_pkg::ST_DEEP); // [R17] [R18]
         program_memory_on <= (next_state == isw_pkg::ST_RUN)
            | (next_state == isw_pkg::ST_WAKE); // [R20]
         core_halt <= (next_state != isw_pkg::ST_RUN); // core resumes after the sleep [R20]
         for (int t = 0; t < 3; t++) begin
            timer_run[t] <= (next_state == isw_pkg::ST_RUN) | (next_state == isw_pkg::ST_WAKE)
               | ((next_state == isw_pkg::ST_LIGHT) // [R13]
               & ~timer_on_sys[t] & ~timer_osc_off[t]);
         end
      end
   end

   // ==========================================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence reti_issue_s;
      core_step && !take && cmd == isw_pkg::CMD_RETI;
   endsequence
   sequence pc_return_s;
      stk_re ##1 (pc_load && gie && !irq_taken);
   endsequence
   sequence popaf_issue_s;
      core_step && !take && cmd == isw_pkg::CMD_POPAF;
   endsequence

   flag_set_a: assert property (|src_hit // [R2]
      |=> ((irq_flags & $past(src_hit)) == $past(src_hit)))
      else $error("source event did not set its flag");
   flag_clear_a: assert property (|($past(irq_flags) & ~irq_flags) // [R2]
      |-> $past(wr_do && is_reg(paddr, isw_pkg::ADDR_IRQ_REQ)))
      else $error("flag cleared without a software write");
   take_vector_a: assert property (take |=> (pc_load && irq_taken && stk_we && !gie // [R7]
      && pc_value == isw_pkg::VECTOR_ADDR && stk_addr == $past(stack_pointer)
      && stack_pointer == $past(stack_pointer) + isw_pkg::SP_STEP))
      else $error("interrupt entry sequence wrong");
   take_cause_a: assert property (irq_taken |-> $past(gie && pending && core_step)) // [R24]
      else $error("vector taken without enabled pending request");
   reti_flow_a: assert property (reti_issue_s |=> pc_return_s) // [R9]
      else $error("return did not restore pc and enable");
   popaf_flow_a: assert property (popaf_issue_s |=> stk_re ##1 af_load) // [R6]
      else $error("accumulator restore sequence wrong");
   deep_timer_a: assert property ((state == isw_pkg::ST_DEEP && !pin_toggle) // [R19]
      |=> state == isw_pkg::ST_DEEP)
      else $error("deep sleep left without a pin toggle");
   light_clock_a: assert property (state == isw_pkg::ST_LIGHT // [R12]
      |-> (!sys_clk_en && slow_rc_osc_en && core_halt && !program_memory_on))
      else $error("light sleep clock gating wrong");
   deep_osc_a: assert property (state == isw_pkg::ST_DEEP // [R18]
      |-> (!slow_rc_osc_en && !fast_rc_osc_en && !crystal_osc_en && !sys_clk_en))
      else $error("oscillator running in deep sleep");
   wake_time_a: assert property (state == isw_pkg::ST_WAKE // [R21]
      && next_state == isw_pkg::ST_RUN
      |-> (wake_cnt + 12'h001 == (wake_fast ? isw_pkg::WAKE_FAST_TICKS
         : isw_pkg::WAKE_NORMAL_TICKS)))
      else $error("wake-up time wrong");
endmodule : isw_ctrl

// File: dv/isw_core_mdl.sv
// stack memory model of the processor core side
`timescale 1ns/100ps
module isw_core_mdl (
   input wire logic core_clk, // system clock
   input wire logic [7:0] stk_addr, // stack address
   input wire logic [15:0] stk_wdata, // stack write data
   input wire logic stk_we, // stack write pulse
   input wire logic stk_re, // stack read pulse
   output logic [15:0] stk_rdata // stack read data
);
   logic [15:0] mem [0:255];
   // ==========================================================================
   // write at the clock edge; the word stands while stk_re is high, because the
   // controller captures it at the edge that ends the read pulse
   always @(posedge core_clk) begin
      if (stk_we) mem[stk_addr] <= stk_wdata;
   end

   // outside the read pulse the bus shows the inverted word so stale data cannot pass
   always_comb stk_rdata = stk_re ? mem[stk_addr] : ~mem[stk_addr];
endmodule : isw_core_mdl

// File: dv/tb_irq_and_sleep_wakeup_control.sv
// self-checking bench of the interrupt and sleep/wake-up controller
`timescale 1ns/100ps
module tb_irq_and_sleep_wakeup_control;
   logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0] paddr = 0, stk_addr, acc_out, flag_out, accumulator = 8'h5A;
   logic [31:0] pwdata = 0, prdata, q;
   logic [6:0] src_level = 0;
   logic core_step = 0, stk_we, stk_re, pc_load, irq_taken, af_load, slow_tick = 0;
   logic [2:0] core_cmd = 0, timer_match = 0, timer_on_sys = 0, timer_osc_off = 0, timer_run;
   logic [15:0] core_pc = 0, stk_rdata, stk_wdata, pc_value, pc0;
   logic [7:0] status_flags = 8'hC3, pin_level = 0, sp0;
   logic comparator_event = 0, fast_rc_cfg = 1, crystal_cfg = 0, fast_boot = 0, e;
   logic sys_clk_en, fast_rc_osc_en, crystal_osc_en, slow_rc_osc_en, program_memory_on;
   logic core_halt, clk_from_slow;
   logic [15:0] exp_q [$];
   int fails = 0, n_checks = 0, i;
   isw_ctrl isw_ctrl_inst (.*);
   isw_core_mdl isw_core_mdl_inst (.*);
   always #4 core_clk = ~core_clk;
   // ==========================================================================
   // verdict and compare
   task end_of_test;
      $display("checks %0d errors %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, s, x);
      end
   endtask : chk
   // apb transfer; waits for pready under a bound, takes data at that edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk) penable <= 1;
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (pready) break;
      end
      if (i == 20) begin fails++; end_of_test(); end
      q = prdata; e = pslverr;
      psel <= 0; penable <= 0;
      @(posedge core_clk);
   endtask : apb
   task step(input logic [2:0] c, input logic [15:0] p);
      core_step <= 1; core_cmd <= c; core_pc <= p;
      @(posedge core_clk) core_step <= 0; core_cmd <= 0;
      repeat (3) @(posedge core_clk);
   endtask : step
   task ticks(input int n);
      repeat (n) begin
         slow_tick <= 1;
         @(posedge core_clk) slow_tick <= 0;
         @(posedge core_clk);
      end
   endtask : ticks
   // monitor: each program counter or accumulator load is matched against the oldest note
   always @(posedge core_clk) if (pc_load || af_load) begin
      if (exp_q.size() == 0) chk(pc_value, 16'hFFFF);
      else chk(pc_load ? pc_value : {flag_out, acc_out}, exp_q.pop_front());
   end
   initial begin
      void'($urandom(32'h7d6062c4));
      sp0 = 8'($urandom) & 8'hFE; // bit 0 kept clear
      pc0 = 16'($urandom);
      repeat (4) @(posedge core_clk);
      rst_n <= 1;
      @(posedge core_clk);
      apb(1, isw_pkg::ADDR_EDGE_SEL, 32'h0000000C); // source 1 on both edges
      @(posedge core_clk) src_level <= 7'h03;
      repeat (2) @(posedge core_clk);
      apb(0, isw_pkg::ADDR_IRQ_REQ, 0); chk(q, 32'h00000003);
      apb(1, isw_pkg::ADDR_IRQ_REQ, 0);
      src_level <= 7'h01;
      repeat (2) @(posedge core_clk);
      apb(0, isw_pkg::ADDR_IRQ_REQ, 0); chk(q, 32'h00000002);
      apb(0, 8'h24, 0); chk(e, 1'b1); // unmapped
      apb(1, isw_pkg::ADDR_IRQ_REQ, 0);
      apb(1, isw_pkg::ADDR_STACK_PTR, {24'h0, sp0});
      apb(1, isw_pkg::ADDR_IRQ_EN, 32'h00000001);
      src_level <= 7'h00;
      @(posedge core_clk) src_level <= 7'h01; // fresh rise on source 0
      repeat (2) @(posedge core_clk);
      step(isw_pkg::CMD_NONE, pc0); // global enable still clear, nothing taken
      step(isw_pkg::CMD_ENGINT, pc0);
      exp_q.push_back(isw_pkg::VECTOR_ADDR);
      step(isw_pkg::CMD_NONE, pc0);
      apb(0, isw_pkg::ADDR_STACK_PTR, 0); chk(q, {24'h0, sp0 + 8'h02});
      apb(0, isw_pkg::ADDR_IRQ_REQ, 0); chk(q, 32'h00000001);
      exp_q.push_back(pc0);
      step(isw_pkg::CMD_RETI, 16'h0011);
      step(isw_pkg::CMD_PUSHAF, 0);
      exp_q.push_back({status_flags, accumulator});
      step(isw_pkg::CMD_POPAF, 0);
      apb(0, isw_pkg::ADDR_STATUS, 0); chk(q[2], 1'b1);
      apb(0, isw_pkg::ADDR_STACK_PTR, 0); chk(q, {24'h0, sp0});
      apb(1, isw_pkg::ADDR_MISC, 32'h00000020);
      apb(1, isw_pkg::ADDR_PIN_WAKE, 32'h00000101);
      timer_on_sys <= 3'h1;
      step(isw_pkg::CMD_LIGHT_SLEEP, 0);
      chk({sys_clk_en, core_halt, program_memory_on, slow_rc_osc_en}, 4'h5);
      chk(timer_run, 3'h6); // system-clocked wide_timer stops
      pin_level <= 8'h01;
      @(posedge core_clk);
      ticks(44); chk(core_halt, 1'b1);
      ticks(1); chk({core_halt, clk_from_slow}, 2'h1);
      step(isw_pkg::CMD_DEEP_SLEEP, 0);
      chk({fast_rc_osc_en, crystal_osc_en, timer_run}, 5'h00);
      timer_match <= 3'h7; comparator_event <= 1;
      ticks(50); chk(core_halt, 1'b1);
      pin_level <= 8'h00;
      @(posedge core_clk);
      ticks(45); chk(core_halt, 1'b0);
      // normal wake-up by the comparator once both of its enables are set
      timer_match <= 3'h0;
      apb(1, isw_pkg::ADDR_MISC, 32'h00000000);
      apb(1, isw_pkg::ADDR_COMP_CTRL, 32'h00000080);
      apb(1, isw_pkg::ADDR_COMP_SEL, 32'h00000040);
      step(isw_pkg::CMD_LIGHT_SLEEP, 0);
      ticks(2999); chk(core_halt, 1'b1);
      ticks(1); chk(core_halt, 1'b0);
      // second reset with the fast boot strap; a byte_timer_b match wakes light sleep
      rst_n <= 0; fast_boot <= 1; timer_match <= 3'h4;
      repeat (2) @(posedge core_clk);
      rst_n <= 1;
      step(isw_pkg::CMD_LIGHT_SLEEP, 0);
      ticks(45); chk(core_halt, 1'b0);
      end_of_test();
   end
endmodule : tb_irq_and_sleep_wakeup_control
